// [logic/dis_pkg.sv]
// Shared constants for the binary input scanner.
package dis_pkg;
  // Structure of the channel array.
  localparam int NUM_INPUTS   = 8;
  localparam int GROUP_SIZE   = 4;
  localparam int NUM_CONTACTS = 4;
  localparam int LVL_W        = 9;
  localparam int DLY_W        = 21;
  localparam int TMR_W        = 22;
  localparam int ADDR_W       = 12;
  localparam int ROUTE_FLD_W  = 4;

  // Time base: core clock period and the millisecond step.
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint MS_PS         = 1000000000;
  localparam int     MS_CYCLES     = int'(MS_PS / CLK_PERIOD_PS);
  localparam int     SCAN_MS       = 5;
  localparam int     AC_STRETCH_MS = 30;
  localparam int     AC_REL_DIV    = 10;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] REG_INFO   = 12'h004;
  localparam logic [ADDR_W-1:0] REG_ROUTE  = 12'h008;
  localparam logic [ADDR_W-1:0] REG_CLEAR  = 12'h00c;
  localparam logic [ADDR_W-1:0] REG_SCANS  = 12'h010;
  localparam logic [ADDR_W-1:0] CH_BASE    = 12'h040;
  localparam int                CH_SHIFT   = 4;
  localparam logic [1:0]        CH_CFG     = 2'h0;
  localparam logic [1:0]        CH_PICK    = 2'h1;
  localparam logic [1:0]        CH_DROP    = 2'h2;
  localparam logic [1:0]        CH_COUNT   = 2'h3;

  // Field positions.
  localparam int STS_RAW_LSB   = 0;
  localparam int STS_STATE_LSB = 8;
  localparam int STS_INT_LSB   = 16;
  localparam int STS_CT_LSB    = 24;
  localparam int INFO_FIRST_LSB = 0;
  localparam int INFO_NUM_LSB  = 8;
  localparam int INFO_GRP_LSB  = 16;
  localparam int CFG_ACT_LSB   = 0;
  localparam int CFG_REL_LSB   = 16;
  localparam int CFG_NC_BIT    = 28;
  localparam int CFG_AC_BIT    = 29;

  // Values after reset.
  localparam logic [LVL_W-1:0] ACT_RST = 9'h058;
  localparam logic [LVL_W-1:0] REL_RST = 9'h03c;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [logic/dis_tick.sv]
// Scan period tick generator.
`timescale 1ns/10ps
`default_nettype none

module dis_tick #(
  parameter int CYCLES = 1250000
)(
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // One-cycle pulse at the end of each scan period.
  output logic      tick_out
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } dis_tick_st_t;

  dis_tick_st_t st;
  dis_tick_st_t next_st;

  // Counts core cycles and pulses once per period.
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'(CYCLES - 1)) begin
      next_st.cnt = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
    if (!resetn_in) begin
      next_st = '0;
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign tick_out = st.tick;

endmodule
`default_nettype wire

// [logic/dis_chan.sv]
// One conditioned binary input channel.
`timescale 1ns/10ps
`default_nettype none

module dis_chan
  import dis_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Scan timing and measured level in volts.
  input  wire logic             scan_tick_in,
  input  wire logic [LVL_W-1:0] level_in,
  // Settings.
  input  wire logic [LVL_W-1:0] act_thr_in,
  input  wire logic [LVL_W-1:0] rel_thr_in,
  input  wire logic             nc_in,
  input  wire logic             ac_in,
  input  wire logic [DLY_W-1:0] pickup_ms_in,
  input  wire logic [DLY_W-1:0] dropoff_ms_in,
  input  wire logic             clear_in,
  // Results.
  output logic                  energised_out,
  output logic                  state_out,
  output logic [31:0]           count_out
);

  typedef struct packed {
    logic             energ;
    logic             state;
    logic [TMR_W-1:0] timer;
    logic [31:0]      count;
  } dis_chan_st_t;

  dis_chan_st_t     st;
  dis_chan_st_t     next_st;
  logic [LVL_W-1:0] rel_eff;
  logic             energ;
  logic             raw;
  logic [TMR_W-1:0] dly;

  // Hysteresis, polarity, delay timing and transition counting.
  always_comb begin
    next_st = st;
    // AC mode forces the release level to a tenth of activation.
    rel_eff = ac_in ? LVL_W'(act_thr_in / LVL_W'(AC_REL_DIV)) : rel_thr_in; // [RULE_11]
    if (st.energ) begin
      energ = (level_in >= rel_eff); // [RULE_13]
    end else begin
      energ = (level_in > act_thr_in); // [RULE_13]
    end
    raw = energ ^ nc_in; // [RULE_09]
    if (raw) begin
      dly = TMR_W'(pickup_ms_in); // [RULE_10]
    end else if (ac_in) begin
      dly = TMR_W'(dropoff_ms_in) + TMR_W'(AC_STRETCH_MS); // [RULE_11]
    end else begin
      dly = TMR_W'(dropoff_ms_in); // [RULE_10]
    end
    if (clear_in) begin
      next_st.count = 32'h0; // [RULE_12]
    end
    // Everything below moves only on a scan tick.
    if (scan_tick_in) begin
      next_st.energ = energ; // [RULE_01]
      if (raw == st.state) begin
        next_st.timer = '0; // [RULE_14]
      end else if (st.timer >= dly) begin
        next_st.state = raw; // [RULE_07]
        next_st.timer = '0;
        if (raw) begin
          next_st.count = next_st.count + 32'h1; // [RULE_12]
        end
      end else begin
        next_st.timer = st.timer + TMR_W'(SCAN_MS); // [RULE_14]
      end
    end
    if (!resetn_in) begin
      next_st = '0;
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign energised_out = st.energ;
  assign state_out     = st.state;
  assign count_out     = st.count;

endmodule
`default_nettype wire

// [logic/dis_scanner.sv]
// Binary input scanner top: register slave, scan pipeline, channel array.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RULE_01] Every input is sampled once per 5 ms scan tick.
// [RULE_02] Internal consumers see an input one scan after it is stored.
// [RULE_03] Routed output contacts update one further scan later.
// [RULE_04] Eight isolated channels form two groups of four sharing returns.
// [RULE_05] Inputs are numbered from preceding count plus one upward.
// [RULE_06] Software sets activation and release thresholds per input in volts.
// [RULE_07] Per input pick-up, release delay and polarity apply within the scan.
// [RULE_08] Every channel uses identical scanning and conditioning logic.
// [RULE_09] Polarity picks whether energised reads one or zero; default one.
// [RULE_10] Rise and fall delays settable in milliseconds, default zero.
// [RULE_11] AC mode adds 30 ms to release delay; off by default.
// [RULE_12] A 32-bit counter of rising transitions, cleared by command.
// [RULE_13] Raw state uses hysteresis between activation and release thresholds.
// [RULE_14] Delays run on scan ticks; the new state must persist throughout.
module dis_scanner
  import dis_pkg::*;
#(
  parameter int N         = NUM_INPUTS,
  parameter int NCT       = NUM_CONTACTS,
  parameter int PRECEDING = 0,
  parameter int MS_CYC    = MS_CYCLES
)(
  // Clock and reset.
  input  wire logic               core_clk_in,
  input  wire logic               resetn_in,
  // Register bus, write address channel.
  input  wire logic               s_axi_awvalid_in,
  output logic                    s_axi_awready_out,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr_in,
  // Register bus, write data channel.
  input  wire logic               s_axi_wvalid_in,
  output logic                    s_axi_wready_out,
  input  wire logic [31:0]        s_axi_wdata_in,
  input  wire logic [3:0]         s_axi_wstrb_in,
  // Register bus, write response channel.
  output logic                    s_axi_bvalid_out,
  input  wire logic               s_axi_bready_in,
  output logic [1:0]              s_axi_bresp_out,
  // Register bus, read address channel.
  input  wire logic               s_axi_arvalid_in,
  output logic                    s_axi_arready_out,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr_in,
  // Register bus, read data channel.
  output logic                    s_axi_rvalid_out,
  input  wire logic               s_axi_rready_in,
  output logic [31:0]             s_axi_rdata_out,
  output logic [1:0]              s_axi_rresp_out,
  // Measured channel levels in volts, channel i at bits i*LVL_W.
  input  wire logic [N*LVL_W-1:0] level_in,
  // Conditioned results.
  output logic [N-1:0]            binary_input_n_out,
  output logic [N-1:0]            internal_state_out,
  output logic [NCT-1:0]          output_contact_n_out,
  output logic                    scan_tick_out
);

  localparam int SCAN_CYC = SCAN_MS * MS_CYC;
  localparam int IDX_W    = ROUTE_FLD_W - 1;

  typedef struct packed {
    logic                              aw_hold;
    logic [ADDR_W-1:0]                 aw_addr;
    logic                              w_hold;
    logic [31:0]                       w_data;
    logic [3:0]                        w_strb;
    logic                              bvalid;
    logic [1:0]                        bresp;
    logic                              rvalid;
    logic [31:0]                       rdata;
    logic [1:0]                        rresp;
    logic [N-1:0][LVL_W-1:0]           act;
    logic [N-1:0][LVL_W-1:0]           rel;
    logic [N-1:0]                      nc;
    logic [N-1:0]                      ac;
    logic [N-1:0][DLY_W-1:0]           pick;
    logic [N-1:0][DLY_W-1:0]           drop;
    logic [NCT-1:0][ROUTE_FLD_W-1:0]   route;
    logic [N-1:0]                      clr;
    logic [N-1:0]                      internal;
    logic [NCT-1:0]                    contact;
    logic [31:0]                       scans;
  } dis_top_st_t;

  dis_top_st_t        st;
  dis_top_st_t        next_st;
  logic               tick;
  logic [N-1:0]       energ;
  logic [N-1:0]       cond;
  logic [N-1:0][31:0] counts;
  logic [31:0]        rd_word;
  logic               rd_ok;
  logic               wr_ok;
  logic [31:0]        wd;
  int                 rch;
  int                 wch;

  // True when an address falls inside the per-channel register window.
  function automatic logic is_chan(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] top;
    top = CH_BASE + ADDR_W'(N << CH_SHIFT);
    return (a >= CH_BASE) && (a < top);
  endfunction

  // Channel index of an address inside the channel window.
  function automatic int ch_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - CH_BASE;
    return int'(off >> CH_SHIFT);
  endfunction

  // Packs one channel's configuration word.
  function automatic logic [31:0] cfg_word(input logic [LVL_W-1:0] act,
                                           input logic [LVL_W-1:0] rel,
                                           input logic nc,
                                           input logic ac);
    logic [31:0] w;
    w = 32'h0;
    w[CFG_ACT_LSB +: LVL_W] = act;
    w[CFG_REL_LSB +: LVL_W] = rel;
    w[CFG_NC_BIT] = nc;
    w[CFG_AC_BIT] = ac;
    return w;
  endfunction

  // Applies byte strobes of a write onto the old word.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Scan period timer.
  dis_tick #(
    .CYCLES (SCAN_CYC)
  ) u_tick (
    .clk_in    (core_clk_in),
    .resetn_in (resetn_in),
    .tick_out  (tick)
  );

  // Identical conditioning for every channel.
  genvar gi;
  for (gi = 0; gi < N; gi++) begin : g_chan
    dis_chan u_chan ( // [RULE_08]
      .clk_in        (core_clk_in),
      .resetn_in     (resetn_in),
      .scan_tick_in  (tick),
      .level_in      (level_in[gi*LVL_W +: LVL_W]),
      .act_thr_in    (st.act[gi]),
      .rel_thr_in    (st.rel[gi]),
      .nc_in         (st.nc[gi]),
      .ac_in         (st.ac[gi]),
      .pickup_ms_in  (st.pick[gi]),
      .dropoff_ms_in (st.drop[gi]),
      .clear_in      (st.clr[gi]),
      .energised_out (energ[gi]),
      .state_out     (cond[gi]),
      .count_out     (counts[gi])
    );
  end

  // Read decode of the address presented on the read channel.
  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    rch = ch_of(s_axi_araddr_in);
    if (s_axi_araddr_in == REG_STATUS) begin
      rd_word[STS_RAW_LSB +: N] = energ;
      rd_word[STS_STATE_LSB +: N] = cond;
      rd_word[STS_INT_LSB +: N] = st.internal;
      rd_word[STS_CT_LSB +: NCT] = st.contact;
    end else if (s_axi_araddr_in == REG_INFO) begin
      rd_word[INFO_FIRST_LSB +: 8] = 8'(PRECEDING + 1); // [RULE_05]
      rd_word[INFO_NUM_LSB +: 8] = 8'(N);
      rd_word[INFO_GRP_LSB +: 8] = 8'(GROUP_SIZE); // [RULE_04]
    end else if (s_axi_araddr_in == REG_ROUTE) begin
      rd_word[NCT*ROUTE_FLD_W-1:0] = st.route;
    end else if (s_axi_araddr_in == REG_CLEAR) begin
      rd_word = 32'h0;
    end else if (s_axi_araddr_in == REG_SCANS) begin
      rd_word = st.scans;
    end else if (is_chan(s_axi_araddr_in)) begin
      case (s_axi_araddr_in[3:2])
        CH_CFG: begin
          rd_word = cfg_word(st.act[rch], st.rel[rch], st.nc[rch], st.ac[rch]);
        end
        CH_PICK: begin
          rd_word[DLY_W-1:0] = st.pick[rch];
        end
        CH_DROP: begin
          rd_word[DLY_W-1:0] = st.drop[rch];
        end
        default: begin
          rd_word = counts[rch]; // [RULE_12]
        end
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Next state: bus slave, register writes and the scan pipeline.
  always_comb begin
    next_st = st;
    next_st.clr = '0;
    wr_ok = 1'b1;
    wd = 32'h0;
    wch = ch_of(st.aw_addr);
    // Address and data are taken independently, in either order.
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = s_axi_wdata_in;
      next_st.w_strb = s_axi_wstrb_in;
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    // Commit a write once both halves are held.
    if (st.aw_hold && st.w_hold && !st.bvalid) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.bvalid = 1'b1;
      if (st.aw_addr == REG_ROUTE) begin
        wd = merge(32'(st.route), st.w_data, st.w_strb);
        next_st.route = wd[NCT*ROUTE_FLD_W-1:0];
      end else if (st.aw_addr == REG_CLEAR) begin
        wd = merge(32'h0, st.w_data, st.w_strb);
        next_st.clr = wd[N-1:0]; // [RULE_12]
      end else if (st.aw_addr == REG_STATUS || st.aw_addr == REG_INFO ||
                   st.aw_addr == REG_SCANS) begin
        wd = 32'h0;
      end else if (is_chan(st.aw_addr)) begin
        case (st.aw_addr[3:2])
          CH_CFG: begin
            wd = merge(cfg_word(st.act[wch], st.rel[wch], st.nc[wch], st.ac[wch]),
                       st.w_data, st.w_strb);
            next_st.act[wch] = wd[CFG_ACT_LSB +: LVL_W]; // [RULE_06]
            next_st.rel[wch] = wd[CFG_REL_LSB +: LVL_W]; // [RULE_06]
            next_st.nc[wch] = wd[CFG_NC_BIT]; // [RULE_07]
            next_st.ac[wch] = wd[CFG_AC_BIT];
          end
          CH_PICK: begin
            wd = merge(32'(st.pick[wch]), st.w_data, st.w_strb);
            next_st.pick[wch] = wd[DLY_W-1:0]; // [RULE_10]
          end
          CH_DROP: begin
            wd = merge(32'(st.drop[wch]), st.w_data, st.w_strb);
            next_st.drop[wch] = wd[DLY_W-1:0]; // [RULE_10]
          end
          default: begin
            wd = 32'h0;
          end
        endcase
      end else begin
        wr_ok = 1'b0;
      end
      next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Read channel: answer registered one cycle after the address is taken.
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Scan pipeline: stored state, then internal use, then contacts.
    if (tick) begin
      next_st.scans = st.scans + 32'h1; // [RULE_01]
      next_st.internal = cond; // [RULE_02]
      for (int k = 0; k < NCT; k++) begin
        if (st.route[k][IDX_W] && (int'(st.route[k][IDX_W-1:0]) < N)) begin
          next_st.contact[k] = st.internal[st.route[k][IDX_W-1:0]]; // [RULE_03]
        end else begin
          next_st.contact[k] = 1'b0;
        end
      end
    end
    // Synchronous reset values.
    if (!resetn_in) begin
      next_st = '0;
      for (int i = 0; i < N; i++) begin
        next_st.act[i] = ACT_RST;
        next_st.rel[i] = REL_RST;
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk_in) begin
    st <= next_st;
  end

  // Handshake outputs from held state.
  assign s_axi_awready_out = !st.aw_hold && !st.bvalid;
  assign s_axi_wready_out  = !st.w_hold && !st.bvalid;
  assign s_axi_arready_out = !st.rvalid;

  // Response and result outputs.
  assign s_axi_bvalid_out     = st.bvalid;
  assign s_axi_bresp_out      = st.bresp;
  assign s_axi_rvalid_out     = st.rvalid;
  assign s_axi_rdata_out      = st.rdata;
  assign s_axi_rresp_out      = st.rresp;
  assign binary_input_n_out   = cond;
  assign internal_state_out   = st.internal;
  assign output_contact_n_out = st.contact;
  assign scan_tick_out        = tick;

endmodule
`default_nettype wire

// [sim/dis_scanner_props.sv]
// Bus handshake and scan pipeline checker for the binary input scanner.
`timescale 1ns/10ps
`default_nettype none

module dis_scanner_props
  import dis_pkg::*;
#(
  parameter int N      = NUM_INPUTS,
  parameter int NCT    = NUM_CONTACTS,
  parameter int MS_CYC = MS_CYCLES
)(
  // Clock and reset.
  input wire logic           core_clk_in,
  input wire logic           resetn_in,
  // Register bus handshakes.
  input wire logic           s_axi_awvalid_in,
  input wire logic           s_axi_awready_out,
  input wire logic           s_axi_wvalid_in,
  input wire logic           s_axi_wready_out,
  input wire logic           s_axi_bvalid_out,
  input wire logic           s_axi_bready_in,
  input wire logic           s_axi_arvalid_in,
  input wire logic           s_axi_arready_out,
  input wire logic           s_axi_rvalid_out,
  input wire logic           s_axi_rready_in,
  // Conditioned results.
  input wire logic [N-1:0]   binary_input_n_out,
  input wire logic [N-1:0]   internal_state_out,
  input wire logic [NCT-1:0] output_contact_n_out,
  input wire logic           scan_tick_out
);
  localparam int SCAN_CYC = SCAN_MS * MS_CYC;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // Cycles since the last scan tick; had marks that one tick was seen.
  int unsigned gap;
  logic        had;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      gap <= 0;
      had <= 1'h0;
    end else if (scan_tick_out) begin
      gap <= 0;
      had <= 1'h1;
    end else begin
      gap <= gap + 1;
    end
  end

  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_bresp_due;
    !s_axi_bvalid_out ##1 s_axi_bvalid_out;
  endsequence

  property p_tick_period;
    had |-> (scan_tick_out == (gap == SCAN_CYC - 1));
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("scan tick spacing wrong");
  property p_state_on_tick;
    !$stable(binary_input_n_out) |-> $past(scan_tick_out);
  endproperty
  a_state_on_tick: assert property (p_state_on_tick) else $error("state moved off tick");
  property p_int_copy;
    scan_tick_out |=> internal_state_out == $past(binary_input_n_out);
  endproperty
  a_int_copy: assert property (p_int_copy) else $error("internal copy wrong");
  property p_int_hold;
    !scan_tick_out |=> $stable(internal_state_out);
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("internal moved off tick");
  property p_ct_hold;
    !scan_tick_out |=> $stable(output_contact_n_out);
  endproperty
  a_ct_hold: assert property (p_ct_hold) else $error("contact moved off tick");
  property p_wr_lat;
    s_wr_taken |=> s_bresp_due;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response timing wrong");
  property p_rd_lat;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_r_drop;
    $fell(s_axi_rvalid_out) |-> $past(s_axi_rready_in);
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read data dropped early");
  property p_b_drop;
    $fell(s_axi_bvalid_out) |-> $past(s_axi_bready_in);
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response dropped early");
  property p_busy_block;
    $rose(s_axi_bvalid_out) |-> !$past(s_axi_awready_out) && !$past(s_axi_wready_out);
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("write answered early");
endmodule

bind dis_scanner dis_scanner_props #(.N(N), .NCT(NCT), .MS_CYC(MS_CYC)) u_props (
  .core_clk_in, .resetn_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in, .binary_input_n_out,
  .internal_state_out, .output_contact_n_out, .scan_tick_out);
`default_nettype wire

// [sim/dis_field.sv]
// Field contact model: supply per input through its shared group return.
`timescale 1ns/10ps
`default_nettype none

module dis_field
  import dis_pkg::*;
(
  // Contact supply per input in volts and return wiring per group.
  input  wire logic [NUM_INPUTS*LVL_W-1:0] supply_in,
  input  wire logic [1:0]                  return_ok_in,
  // Level seen at each isolated input.
  output logic      [NUM_INPUTS*LVL_W-1:0] level_out
);
  // An open group return de-energises all four inputs sharing it.
  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (return_ok_in[i / GROUP_SIZE]) begin
        level_out[i*LVL_W +: LVL_W] = supply_in[i*LVL_W +: LVL_W];
      end else begin
        level_out[i*LVL_W +: LVL_W] = 9'h000;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the binary input scanner.
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import dis_pkg::*;
();
  logic clk = 1'h0, resetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hf, contact;
  logic [NUM_INPUTS*LVL_W-1:0] supply = 72'h0, level;
  logic [1:0] ret_ok = 2'h3, bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, tick;
  logic [7:0] state, internal;
  logic [7:0] ex_s [3] = '{8'h85, 8'h85, 8'h87};
  logic [7:0] ex_i [3] = '{8'h80, 8'h85, 8'h85};
  logic [3:0] ex_c [3] = '{4'h2, 4'h2, 4'h3};
  int error_cnt = 0, num_checks = 0, k;

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  dis_field u_dis_field (.supply_in(supply), .return_ok_in(ret_ok), .level_out(level));

  dis_scanner #(.PRECEDING(3), .MS_CYC(4)) u_dis_scanner (
    .core_clk_in(clk), .resetn_in(resetn),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .level_in(level),
    .binary_input_n_out(state), .internal_state_out(internal),
    .output_contact_n_out(contact), .scan_tick_out(tick));

  // Prints the verdict and stops.
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // A wait that ran out ends the run as a mismatch.
  task automatic hang();
    error_cnt++;
    end_of_test();
  endtask

  // Bus write; handshakes are seen mid-cycle and acted on at the next edge.
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ah, wh, bh = 1'h0;
    @(posedge clk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= v;
    bready <= 1'h1;
    for (int n = 0; n < 64 && !bh; n++) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      if (bh) bready <= 1'h0;
    end
    if (!bh) hang();
  endtask

  // Bus read in the same manner.
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ah, dh = 1'h0;
    @(posedge clk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    for (int n = 0; n < 64 && !dh; n++) begin
      @(negedge clk);
      ah = arvalid && arready;
      dh = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'h0;
      if (dh) rready <= 1'h0;
    end
    if (!dh) hang();
  endtask

  // Returns a few cycles after the next scan tick, once results settled.
  task automatic wait_tick();
    logic seen = 1'h0;
    for (int n = 0; n < 64 && !seen; n++) begin
      @(negedge clk);
      seen = tick;
    end
    if (!seen) hang();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic set_lvl(input int ch, input logic [LVL_W-1:0] v);
    @(posedge clk);
    supply[ch*LVL_W +: LVL_W] <= v;
  endtask

  function automatic logic [11:0] cha(input int ch, input int w);
    return CH_BASE + 12'(ch << CH_SHIFT) + 12'(4 * w);
  endfunction

  // Main sequence: registers first, then the scan pipeline.
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    rd(REG_INFO, d, r);
    chk("info", 32'h00040804, d);
    rd(cha(0, 0), d, r);
    chk("cfg reset", 32'h003c0058, d);
    rd(cha(0, 1), d, r);
    chk("pickup reset", 32'h0, d);
    rd(12'h030, d, r);
    chk("unmapped rd resp", RESP_SLVERR, r);
    chk("unmapped rd data", 32'h0, d);
    wr(12'h030, 32'h1, r);
    chk("unmapped wr resp", RESP_SLVERR, r);
    wr(REG_STATUS, 32'hffffffff, r);
    chk("ro wr resp", RESP_OKAY, r);
    wr(REG_ROUTE, 32'h000000f8, r);
    rd(REG_ROUTE, d, r);
    chk("route", 32'h000000f8, d);
    wr(cha(1, 1), 32'h0000000a, r);
    rd(cha(1, 1), d, r);
    chk("pickup", 32'h0000000a, d);
    wr(cha(2, 0), 32'h20000058, r);
    wr(cha(7, 0), 32'h103c0058, r);
    wr(cha(3, 0), 32'h00640078, r);
    wr(cha(3, 2), 32'h00000005, r);
    rd(cha(3, 0), d, r);
    chk("thresholds", 32'h00640078, d);
    repeat (3) wait_tick();
    set_lvl(0, 9'h064);
    set_lvl(1, 9'h064);
    set_lvl(2, 9'h064);
    set_lvl(3, 9'h06e);
    for (k = 0; k < 3; k++) begin
      wait_tick();
      chk("state", ex_s[k], state);
      chk("internal", ex_i[k], internal);
      chk("contact", ex_c[k], contact);
    end
    rd(cha(0, 3), d, r);
    chk("count", 32'h1, d);
    set_lvl(0, 9'h046);
    set_lvl(2, 9'h032);
    set_lvl(3, 9'h079);
    set_lvl(7, 9'h064);
    wait_tick();
    chk("hysteresis", 8'h0f, state);
    rd(REG_STATUS, d, r);
    chk("status", 32'h03870f8f, d);
    set_lvl(0, 9'h032);
    set_lvl(2, 9'h000);
    set_lvl(3, 9'h069);
    for (k = 0; k < 7; k++) begin
      wait_tick();
      chk("ac stretch", k < 6, state[2]);
      chk("release", k > 1, state[0]);
      chk("hold", 32'h1, state[3]);
      if (k == 0) set_lvl(0, 9'h058);
      if (k == 1) set_lvl(0, 9'h059);
    end
    rd(cha(0, 3), d, r);
    chk("count", 32'h2, d);
    wr(REG_CLEAR, 32'h1, r);
    rd(cha(0, 3), d, r);
    chk("cleared", 32'h0, d);
    rd(REG_CLEAR, d, r);
    chk("clear reads", 32'h0, d);
    rd(cha(2, 3), d, r);
    chk("count other", 32'h1, d);
    @(posedge clk);
    ret_ok <= 2'h1;
    supply[3*LVL_W +: LVL_W] <= 9'h000;
    wait_tick();
    chk("return open", 32'h8b, state);
    wait_tick();
    chk("drop delay", 32'h83, state);
    end_of_test();
  end
endmodule
`default_nettype wire
